// [src/dtc_pkg.sv]
package dtc_pkg;
  // Host side field layout of a group's basic byte.
  localparam int GRP_LSB = 0;
  localparam int GRP_W = 3;
  localparam int FOL_LSB = 3;
  localparam int FOL_W = 5;
  localparam int NUM_GROUPS = 7;
  localparam int NUM_REL = 14;
  localparam int NUM_RD = 7;
  // First related-register index of each group, and how many it owns.
  localparam logic [3:0] REL_BASE [0:6] = '{4'h0, 4'h4, 4'h5, 4'h6, 4'h8, 4'hd, 4'hd};
  localparam logic [4:0] REL_MASK [0:6] = '{5'h0f, 5'h01, 5'h01, 5'h03, 5'h1f, 5'h00, 5'h01};
  // Related-register indices.
  localparam logic [3:0] RI_A_LO = 4'h0;
  localparam logic [3:0] RI_A_HI = 4'h1;
  localparam logic [3:0] RI_LEN_LO = 4'h2;
  localparam logic [3:0] RI_LEN_HI = 4'h3;
  localparam logic [3:0] RI_MASK = 4'h6;
  localparam logic [3:0] RI_MATCH = 4'h7;
  localparam logic [3:0] RI_B_LO = 4'h8;
  localparam logic [3:0] RI_B_HI = 4'h9;
  localparam logic [3:0] RI_INTCTL = 4'ha;
  // Basic-byte configuration bits.
  localparam int B0_DIR_A2B = 3;
  localparam int B1_A_IO = 3;
  localparam int B2_B_IO = 3;
  localparam int B3_SEARCH = 3;
  localparam int B5_RDY_HIGH = 3;
  // Interrupt control byte bits.
  localparam int IC_ON_MATCH = 0;
  localparam int IC_ON_END = 1;
  localparam int IC_PULSE = 2;
  // Commands carried in the upper nibble of group 6's basic byte.
  localparam logic [3:0] CMD_NONE = 4'h0;
  localparam logic [3:0] CMD_RESET = 4'h1;
  localparam logic [3:0] CMD_ENABLE = 4'h2;
  localparam logic [3:0] CMD_DISABLE = 4'h3;
  localparam logic [3:0] CMD_READ_INIT = 4'h4;
  localparam logic [3:0] CMD_CLR_INT = 4'h5;
  // Status byte bits.
  localparam int ST_B_READY = 0;
  localparam int ST_B_MATCH = 1;
  localparam int ST_B_END = 2;
  localparam int ST_B_BUSY = 3;
  // The fetch flag must stay low longer than this many clocks.
  localparam logic [1:0] FETCH_MIN_CLKS = 2'd2;
  localparam int FIFO_W = 8;
  localparam int FIFO_D = 16;
  typedef enum logic [2:0]
  {
    ST_IDLE = 3'b000,
    ST_REQ = 3'b001,
    ST_XFER = 3'b010,
    ST_RD = 3'b011,
    ST_WR = 3'b100,
    ST_DONE = 3'b101
  } dtc_state_t;
endpackage : dtc_pkg

// [src/dtc_top.sv]
// Operation
// [R01] Long fetch flag without read/io resets.
// [R02] Power-on reset synchronised into logic.
// [R03] 21 writable, 7 readable registers.
// [R04] Bytes; 16-bit values in pairs.
// [R05] Basic byte picks following related writes.
// [R06] Readback: status, count, A, B.
// [R07] Programming: address off, data out reads.
// [R08] Owner drives control and address.
// [R09] Receive on reads, drive on writes.
// [R10] Request only when enabled and ready.
// [R11] Processor idles while bus granted.
// [R12] Pulse every 256 transferred bytes.
// [R13] Counter cleared at start, counts bytes.
// [R14] End when count equals block length.
// [R15] Pattern match may raise interrupt.
// [R16] Direction bit picks source port.
// [R17] Interrupt enable daisy chain.
// [R18] Nested interrupts by higher priority.
// [R19] Hold off while other requests.
// [R20] Keep bus until operation completes.
// [R21] Grant chain blocks lower positions.
// [R22] Software reset command.
`timescale 1ns/1ps
`default_nettype none

// Byte FIFO between the read and write halves of a transfer.
module dtc_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_clr,
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [W-1:0] i_data,
  output logic o_valid,
  input wire logic i_ready,
  output logic [W-1:0] o_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [0:D-1]; // Storage.
  logic [AW-1:0] wp_q; // Write pointer.
  logic [AW-1:0] rp_q; // Read pointer.
  logic [AW:0] cnt_q; // Fill level.
  logic push;
  logic pop;
  // The level is one bit wider than the pointers, so full and empty differ.
  assign o_ready = cnt_q < (AW+1)'(D);
  assign o_valid = cnt_q != '0;
  assign push = i_valid && o_ready;
  assign pop = i_ready && o_valid;
  assign o_data = mem[rp_q];

  // Memory has no reset; only pointers and level carry state.
  always_ff @(posedge i_mclk)
  begin
    if (push)
      mem[wp_q] <= i_data;
  end

  // Pointers and level; a clear drops anything left over.
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end
    else if (i_clr)
    begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
        wp_q <= wp_q + 1'b1;
      if (pop)
        rp_q <= rp_q + 1'b1;
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : dtc_fifo

module dtc_top
  import dtc_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_ce_n,
  input wire logic i_rd_n,
  input wire logic i_wr_n,
  input wire logic i_io_request_strobe_n,
  input wire logic i_fetch_n,
  input wire logic [7:0] i_data,
  output logic [7:0] o_data,
  output logic o_data_oe_n,
  output logic [15:0] o_addr,
  output logic o_addr_oe_n,
  output logic o_rd_n,
  output logic o_wr_n,
  output logic o_mreq_n,
  output logic o_io_request_strobe_n,
  output logic o_ctl_oe_n,
  input wire logic i_ready,
  input wire logic i_bus_request_line_n,
  output logic o_bus_request_line_n,
  output logic o_bus_request_line_oe_n,
  input wire logic i_grant_in_n,
  output logic o_grant_out_n,
  input wire logic i_irq_en_in,
  output logic o_irq_en_out,
  output logic o_int_n,
  output logic o_int_oe_n
);
  dtc_state_t st_q; // Transfer sequencer.
  logic [7:0] bas_q [0:NUM_GROUPS-1]; // Basic registers.
  logic [7:0] rel_q [0:NUM_REL-1]; // Related registers.
  logic [2:0] grp_q; // Group of the last basic write.
  logic [FOL_W-1:0] pend_q; // Related writes still expected.
  logic [2:0] rptr_q; // Readback position.
  logic [15:0] cnt_q; // Byte counter.
  logic [15:0] rcnt_q; // Bytes read so far.
  logic [15:0] aadr_q; // Port A address counter.
  logic [15:0] badr_q; // Port B address counter.
  logic en_q, match_q, end_q, pulse_q, ipend_q;
  logic por_q; // Stretched power-on reset.
  logic [1:0] fcnt_q; // Fetch-low length, saturating.
  logic fetch_q; // Fetch flag one clock ago.
  logic hwr_q, hrd_q; // Host strobes one clock ago.
  logic srst; // Synchronous reset from any source.
  logic ext_rst, sw_rst;
  logic hwr_now, hrd_now, hwr_p, hrd_end;
  logic [2:0] wgrp;
  logic [3:0] cmd;
  logic rdy_ok, owner, a2b, len_hit;
  logic [15:0] len;
  logic f_ready, f_valid, f_push, f_pop;
  logic [7:0] f_dout;

  assign hwr_now = !i_ce_n && !i_io_request_strobe_n && !i_wr_n && !owner;
  assign hrd_now = !i_ce_n && !i_io_request_strobe_n && !i_rd_n && !owner;
  assign hwr_p = hwr_now && !hwr_q;
  assign hrd_end = hrd_q && !hrd_now;
  assign wgrp = i_data[GRP_LSB +: GRP_W];
  assign cmd = i_data[7:4];
  assign owner = (st_q == ST_XFER) || (st_q == ST_RD) || (st_q == ST_WR);
  assign rdy_ok = i_ready == bas_q[5][B5_RDY_HIGH];
  // [R16] source select
  assign a2b = bas_q[0][B0_DIR_A2B];
  assign len = {rel_q[RI_LEN_HI], rel_q[RI_LEN_LO]};
  // [R14] length compare
  assign len_hit = cnt_q == len;
  // [R01] fetch reset
  assign ext_rst = i_fetch_n && !fetch_q && (fcnt_q > FETCH_MIN_CLKS);
  // [R22] software reset
  assign sw_rst = hwr_p && (pend_q == '0) && (wgrp == 3'd6) && (cmd == CMD_RESET);
  assign srst = por_q || ext_rst || sw_rst;

  // Power-on reset stays set one clock after release, so the rest of the
  // logic leaves reset on a clean edge rather than on the async release.
  // [R02] synchronous power-on
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
      por_q <= 1'b1;
    else
      por_q <= 1'b0;
  end

  // Count how long the fetch flag is low with neither read nor io strobe.
  // A read or io strobe in the window disqualifies the reset.
  // [R01] fetch length
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      fcnt_q <= '0;
      fetch_q <= 1'b1;
    end
    else
    begin
      fetch_q <= i_fetch_n;
      if (i_fetch_n || !i_rd_n || !i_io_request_strobe_n)
        fcnt_q <= '0;
      else if (fcnt_q != 2'd3)
        fcnt_q <= fcnt_q + 1'b1;
    end
  end
  // Note: ext_rst fires on the rising edge, seen as high now, low before.
  // fetch_q holds the old level; i_fetch_n high completes the edge.

  // Host strobe history for edge detection.
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      hwr_q <= 1'b0;
      hrd_q <= 1'b0;
    end
    else
    begin
      hwr_q <= hwr_now;
      hrd_q <= hrd_now;
    end
  end

  // Register writes: a basic byte names its group and which related
  // registers follow; those are then taken in ascending order.
  // [R03] register file
  // [R05] group sequencing
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      grp_q <= '0;
      pend_q <= '0;
      for (int i = 0; i < NUM_GROUPS; i++)
        bas_q[i] <= 8'h00;
      for (int i = 0; i < NUM_REL; i++)
        rel_q[i] <= 8'h00;
    end
    else if (srst)
    begin
      grp_q <= '0;
      pend_q <= '0;
    end
    else if (hwr_p)
    begin
      if (pend_q == '0)
      begin
        bas_q[wgrp] <= i_data;
        grp_q <= wgrp;
        pend_q <= i_data[FOL_LSB +: FOL_W] & REL_MASK[wgrp];
      end
      else
      begin
        // Lowest pending slot first; a 16-bit value takes two slots, low byte first.
        // [R04] byte pairs
        for (int k = FOL_W - 1; k >= 0; k--)
        begin
          if (pend_q[k])
            rel_q[REL_BASE[grp_q] + 4'(k)] <= i_data;
        end
        pend_q <= pend_q & (pend_q - 1'b1);
      end
    end
  end

  // Readback pointer walks the seven status bytes and wraps.
  // [R06] readback order
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
      rptr_q <= '0;
    else if (srst)
      rptr_q <= '0;
    else if (hwr_p && pend_q == '0 && wgrp == 3'd6 && cmd == CMD_READ_INIT)
      rptr_q <= '0;
    else if (hrd_end)
      rptr_q <= (rptr_q == 3'(NUM_RD - 1)) ? 3'd0 : rptr_q + 1'b1;
  end

  // Enable flag: set and cleared by command, dropped at block end.
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
      en_q <= 1'b0;
    else if (srst)
      en_q <= 1'b0;
    else if (hwr_p && pend_q == '0 && wgrp == 3'd6 && cmd == CMD_ENABLE)
      en_q <= 1'b1;
    else if (st_q == ST_DONE
             || (hwr_p && pend_q == '0 && wgrp == 3'd6 && cmd == CMD_DISABLE))
      en_q <= 1'b0;
  end

  // Transfer sequencer. The bus is held from grant until the block ends;
  // nothing but reset takes it away. Reads fill the FIFO while it has room
  // and the peripheral is ready; writes drain it.
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
      st_q <= ST_IDLE;
    else if (srst)
      st_q <= ST_IDLE;
    else
    begin
      case (st_q)
        ST_IDLE:
          // [R10] request conditions
          // [R19] wait for other
          if (en_q && rdy_ok && i_bus_request_line_n)
            st_q <= ST_REQ;
        ST_REQ:
          if (!en_q)
            st_q <= ST_IDLE;
          else if (!i_grant_in_n)
            st_q <= ST_XFER;
        ST_XFER:
          // [R20] hold until done
          if (len_hit && !f_valid)
            st_q <= ST_DONE;
          else if (rcnt_q != len && f_ready && rdy_ok)
            st_q <= ST_RD;
          else if (f_valid)
            st_q <= ST_WR;
        ST_RD: st_q <= ST_XFER;
        ST_WR: st_q <= ST_XFER;
        ST_DONE: st_q <= ST_IDLE;
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // Counters and address pointers. The source advances on reads, the
  // destination on writes; the byte counter counts completed writes.
  // [R13] byte counter
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      cnt_q <= '0;
      rcnt_q <= '0;
      aadr_q <= '0;
      badr_q <= '0;
    end
    else if (srst)
    begin
      cnt_q <= '0;
      rcnt_q <= '0;
    end
    else if (st_q == ST_REQ && !i_grant_in_n)
    begin
      cnt_q <= '0;
      rcnt_q <= '0;
      aadr_q <= {rel_q[RI_A_HI], rel_q[RI_A_LO]};
      badr_q <= {rel_q[RI_B_HI], rel_q[RI_B_LO]};
    end
    else if (st_q == ST_RD)
    begin
      rcnt_q <= rcnt_q + 1'b1;
      if (a2b)
        aadr_q <= aadr_q + 1'b1;
      else
        badr_q <= badr_q + 1'b1;
    end
    else if (st_q == ST_WR)
    begin
      cnt_q <= cnt_q + 1'b1;
      if (a2b)
        badr_q <= badr_q + 1'b1;
      else
        aadr_q <= aadr_q + 1'b1;
    end
  end

  // Byte FIFO: reads push the sampled bus, writes pop the head.
  assign f_push = st_q == ST_RD;
  assign f_pop = st_q == ST_XFER && !(rcnt_q != len && f_ready && rdy_ok)
                 && f_valid && !(len_hit && !f_valid);

  dtc_fifo #(
    .W(FIFO_W),
    .D(FIFO_D)
  ) u_fifo (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_clr(srst),
    .i_valid(f_push),
    .o_ready(f_ready),
    .i_data(i_data),
    .o_valid(f_valid),
    .i_ready(f_pop),
    .o_data(f_dout)
  );

  // Status flags. A new event wins over a clear in the same cycle.
  // [R15] match detect
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      match_q <= 1'b0;
      end_q <= 1'b0;
      ipend_q <= 1'b0;
    end
    else if (srst)
    begin
      match_q <= 1'b0;
      end_q <= 1'b0;
      ipend_q <= 1'b0;
    end
    else
    begin
      if (f_push && bas_q[3][B3_SEARCH]
          && ((i_data | rel_q[RI_MASK]) == (rel_q[RI_MATCH] | rel_q[RI_MASK])))
      begin
        match_q <= 1'b1;
        if (rel_q[RI_INTCTL][IC_ON_MATCH])
          ipend_q <= 1'b1;
      end
      else if (st_q == ST_DONE)
      begin
        end_q <= 1'b1;
        if (rel_q[RI_INTCTL][IC_ON_END])
          ipend_q <= 1'b1;
      end
      else if (hwr_p && pend_q == '0 && wgrp == 3'd6 && cmd == CMD_CLR_INT)
      begin
        ipend_q <= 1'b0;
        match_q <= 1'b0;
        end_q <= 1'b0;
      end
    end
  end

  // One-clock pulse each time the byte counter crosses a 256 boundary.
  // [R12] 256-byte pulse
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
      pulse_q <= 1'b0;
    else
      pulse_q <= !srst && st_q == ST_WR && cnt_q[7:0] == 8'hff
                 && rel_q[RI_INTCTL][IC_PULSE];
  end

  // Interrupt pin and enable chain. A pending interrupt blocks lower
  // devices; once cleared, the chain reopens so nesting works.
  // [R17] interrupt chain
  // [R18] nesting allowed
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_int_n <= 1'b0;
      o_int_oe_n <= 1'b1;
      o_irq_en_out <= 1'b0;
    end
    else
    begin
      o_int_n <= 1'b0;
      o_int_oe_n <= !((ipend_q && i_irq_en_in) || pulse_q);
      o_irq_en_out <= i_irq_en_in && !ipend_q;
    end
  end

  // Bus request and grant chain; a device that requests keeps the grant.
  // [R21] grant chain
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_bus_request_line_n <= 1'b0;
      o_bus_request_line_oe_n <= 1'b1;
      o_grant_out_n <= 1'b1;
    end
    else
    begin
      o_bus_request_line_n <= 1'b0;
      o_bus_request_line_oe_n <= !(st_q == ST_REQ || owner) || srst;
      o_grant_out_n <= i_grant_in_n || st_q != ST_IDLE;
    end
  end

  // Bus pins: address and control only while owning the bus.
  // [R07] programming direction
  // [R08] owner drives
  // [R09] data direction
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_addr <= '0;
      o_addr_oe_n <= 1'b1;
      o_ctl_oe_n <= 1'b1;
      o_rd_n <= 1'b1;
      o_wr_n <= 1'b1;
      o_mreq_n <= 1'b1;
      o_io_request_strobe_n <= 1'b1;
      o_data <= '0;
      o_data_oe_n <= 1'b1;
    end
    else
    begin
      o_addr_oe_n <= 1'b1;
      o_ctl_oe_n <= 1'b1;
      o_rd_n <= 1'b1;
      o_wr_n <= 1'b1;
      o_mreq_n <= 1'b1;
      o_io_request_strobe_n <= 1'b1;
      o_data_oe_n <= 1'b1;
      // Drivers stay on for the whole ownership, so the bus never floats
      // between the access cycles of one block.
      if (owner && !srst)
      begin
        o_addr_oe_n <= 1'b0;
        o_ctl_oe_n <= 1'b0;
      end
      if (st_q == ST_XFER && !srst)
      begin
        if (rcnt_q != len && f_ready && rdy_ok && !(len_hit && !f_valid))
        begin
          o_addr <= a2b ? aadr_q : badr_q;
          o_rd_n <= 1'b0;
          o_io_request_strobe_n <= !(a2b ? bas_q[1][B1_A_IO] : bas_q[2][B2_B_IO]);
          o_mreq_n <= a2b ? bas_q[1][B1_A_IO] : bas_q[2][B2_B_IO];
        end
        else if (f_pop)
        begin
          o_addr <= a2b ? badr_q : aadr_q;
          o_wr_n <= 1'b0;
          o_io_request_strobe_n <= !(a2b ? bas_q[2][B2_B_IO] : bas_q[1][B1_A_IO]);
          o_mreq_n <= a2b ? bas_q[2][B2_B_IO] : bas_q[1][B1_A_IO];
          o_data <= f_dout;
          o_data_oe_n <= 1'b0;
        end
      end
      else if (hrd_now)
      begin
        o_data_oe_n <= 1'b0;
        case (rptr_q)
          3'd0: o_data <= {4'h0, ipend_q, end_q, match_q, i_ready};
          3'd1: o_data <= cnt_q[7:0];
          3'd2: o_data <= cnt_q[15:8];
          3'd3: o_data <= aadr_q[7:0];
          3'd4: o_data <= aadr_q[15:8];
          3'd5: o_data <= badr_q[7:0];
          3'd6: o_data <= badr_q[15:8];
          default: o_data <= 8'h00;
        endcase
      end
    end
  end

  property p_req;
    @(posedge i_mclk) disable iff (i_rst)
    $fell(o_bus_request_line_oe_n) |-> $past(en_q, 2);
  endproperty
  a_req: assert property (p_req) // [R10]
    else $error("bus requested without enable");
  property p_rd_drive;
    @(posedge i_mclk) disable iff (i_rst)
    !o_rd_n |-> !o_addr_oe_n && !o_ctl_oe_n && o_data_oe_n;
  endproperty
  a_rd_drive: assert property (p_rd_drive) // [R08]
    else $error("read cycle without bus drive");
  property p_wr_data;
    @(posedge i_mclk) disable iff (i_rst)
    !o_wr_n |-> !o_data_oe_n && !o_addr_oe_n;
  endproperty
  a_wr_data: assert property (p_wr_data) // [R09]
    else $error("write cycle without data drive");
  property p_prog;
    @(posedge i_mclk) disable iff (i_rst)
    (st_q == ST_IDLE) |=> o_addr_oe_n;
  endproperty
  a_prog: assert property (p_prog) // [R07]
    else $error("address driven while idle");
  property p_cnt_clr;
    @(posedge i_mclk) disable iff (i_rst)
    (st_q == ST_REQ && !i_grant_in_n && !srst) |=> (cnt_q == 16'h0000);
  endproperty
  a_cnt_clr: assert property (p_cnt_clr) // [R13]
    else $error("byte counter not cleared at start");
  property p_end;
    @(posedge i_mclk) disable iff (i_rst)
    (st_q == ST_XFER && len_hit && !f_valid && !srst) |=> st_q == ST_DONE ##1 !en_q;
  endproperty
  a_end: assert property (p_end) // [R14]
    else $error("block end missed");
  property p_hold;
    @(posedge i_mclk) disable iff (i_rst)
    (st_q == ST_IDLE && !i_bus_request_line_n) |=> st_q != ST_REQ;
  endproperty
  a_hold: assert property (p_hold) // [R19]
    else $error("requested while bus held by another");
  property p_chain;
    @(posedge i_mclk) disable iff (i_rst)
    (st_q == ST_REQ) |=> o_grant_out_n;
  endproperty
  a_chain: assert property (p_chain) // [R21]
    else $error("grant passed on while requesting");
  property p_ext;
    @(posedge i_mclk) disable iff (i_rst)
    ext_rst |=> !en_q && st_q == ST_IDLE;
  endproperty
  a_ext: assert property (p_ext) // [R01]
    else $error("fetch reset had no effect");
endmodule : dtc_top
`default_nettype wire

// [tb/dtc_bus_model.sv]
`timescale 1ns/1ps
`default_nettype none

// Memory and ports beyond the system bus, seen while the block is master.
module dtc_bus_model (
  input wire logic i_mclk,
  input wire logic [15:0] i_addr,
  input wire logic i_rd_n,
  input wire logic i_wr_n,
  input wire logic i_ctl_oe_n,
  input wire logic [7:0] i_data,
  output logic [7:0] o_data
);
  // One kilobyte; upper address bits alias onto it.
  logic [7:0] mem [0:1023];
  // Last byte answered; its inverse shows once the bus is released.
  logic [7:0] last_q;

  // Fill with a pattern so that copies are visible.
  initial
  begin
    last_q = 8'h00;
    for (int i = 0; i < 1024; i++)
    begin
      mem[i] = i[7:0] ^ {i[9:8], 6'h2a};
    end
  end

  always_comb
  begin
    if (!i_ctl_oe_n && !i_rd_n)
    begin
      o_data = mem[i_addr[9:0]];
    end
    else
    begin
      // A stale value would hide a late sample.
      o_data = ~last_q;
    end
  end

  always @(posedge i_mclk)
  begin
    if (!i_ctl_oe_n && !i_rd_n)
    begin
      last_q <= o_data;
    end
    if (!i_ctl_oe_n && !i_wr_n)
    begin
      mem[i_addr[9:0]] <= i_data;
    end
  end
endmodule : dtc_bus_model

`default_nettype wire

// [tb/dtc_top_tb.sv]
`timescale 1ns/1ps
`default_nettype none

// Programs the block as a host, lends it the bus and checks the copy.
module dtc_top_tb;
  import dtc_pkg::*;
  logic i_mclk = 1'b0;
  logic i_rst = 1'b1;
  // Chip enable and io strobe move together for host cycles.
  logic sel_n = 1'b1;
  logic rd_n = 1'b1;
  logic wr_n = 1'b1;
  logic fetch_n = 1'b1;
  logic host_oe = 1'b0;
  logic [7:0] host_d = 8'h00;
  logic ready = 1'b0;
  logic ext_req = 1'b0;
  logic hold_g = 1'b1;
  logic grant_n = 1'b1;
  logic irq_in = 1'b1;
  logic cnt_on = 1'b0;
  int pulses = 0;
  int cycles = 0;
  int miscompares = 0;
  int n_compared = 0;
  logic [7:0] rb [0:6];
  logic [7:0] o_data, mem_d, bus_d;
  logic [15:0] o_addr;
  logic o_data_oe_n, o_addr_oe_n, o_rd_n, o_wr_n, o_ctl_oe_n;
  logic o_bus_request_line_oe_n, o_grant_out_n, o_irq_en_out, o_int_oe_n;
  logic mreq_n, io_request_strobe_n, bus_request_line_n, int_n;
  logic [15:0] src_a; // Source address of the byte being checked.
  wire bus_request_line_line;

  // Open-drain request line: low when either master pulls it.
  assign bus_request_line_line = (o_bus_request_line_oe_n | bus_request_line_n) & ~ext_req;
  assign bus_d = host_oe ? host_d : mem_d;

  always #12.5 i_mclk = ~i_mclk;

  dtc_top i_dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_ce_n(sel_n), .i_rd_n(rd_n),
    .i_wr_n(wr_n), .i_io_request_strobe_n(sel_n), .i_fetch_n(fetch_n), .i_data(bus_d),
    .o_data(o_data), .o_data_oe_n(o_data_oe_n), .o_addr(o_addr),
    .o_addr_oe_n(o_addr_oe_n), .o_rd_n(o_rd_n), .o_wr_n(o_wr_n), .o_mreq_n(mreq_n),
    .o_io_request_strobe_n(io_request_strobe_n), .o_ctl_oe_n(o_ctl_oe_n), .i_ready(ready), .i_bus_request_line_n(bus_request_line_line),
    .o_bus_request_line_n(bus_request_line_n), .o_bus_request_line_oe_n(o_bus_request_line_oe_n), .i_grant_in_n(grant_n),
    .o_grant_out_n(o_grant_out_n), .i_irq_en_in(irq_in), .o_irq_en_out(o_irq_en_out),
    .o_int_n(int_n), .o_int_oe_n(o_int_oe_n));

  // The memory answers only a memory cycle: request low, io strobe high.
  dtc_bus_model i_mem (.i_mclk(i_mclk), .i_addr(o_addr), .i_rd_n(o_rd_n),
    .i_wr_n(o_wr_n), .i_ctl_oe_n(o_ctl_oe_n | mreq_n | ~io_request_strobe_n), .i_data(o_data),
    .o_data(mem_d));

  always @(negedge i_mclk)
  begin
    grant_n <= o_bus_request_line_oe_n | hold_g;
  end

  // Counts interrupt-line low cycles and cuts a hang short.
  always @(posedge i_mclk)
  begin
    cycles++;
    if (cnt_on && o_int_oe_n === 1'b0 && int_n === 1'b0)
    begin
      pulses++;
    end
    if (cycles == 20000)
    begin
      miscompares++;
      summarize();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Host write; the strobe rests high two clocks before the next one.
  task automatic hwr(input logic [7:0] d);
    @(negedge i_mclk);
    host_d = d;
    host_oe = 1'b1;
    sel_n = 1'b0;
    wr_n = 1'b0;
    @(negedge i_mclk);
    sel_n = 1'b1;
    wr_n = 1'b1;
    host_oe = 1'b0;
    @(negedge i_mclk);
  endtask : hwr

  // Host read; data is taken once it has settled.
  task automatic hrd(output logic [7:0] d);
    @(negedge i_mclk);
    sel_n = 1'b0;
    rd_n = 1'b0;
    @(negedge i_mclk);
    @(negedge i_mclk);
    check(o_addr_oe_n, 1'b1);
    d = o_data;
    sel_n = 1'b1;
    rd_n = 1'b1;
    @(negedge i_mclk);
  endtask : hrd

  // Bounded wait for the request pin to reach a level.
  task automatic wait_req(input logic lvl);
    int n;
    n = 0;
    while (o_bus_request_line_oe_n !== lvl && n < 3000)
    begin
      @(negedge i_mclk);
      n++;
    end
    check(o_bus_request_line_oe_n, lvl);
  endtask : wait_req

  // Short block from port B to port A with the bus lent; the grant must be
  // open, or the block would sit in its request forever.
  task automatic run(input logic [7:0] ln, input logic [7:0] ic);
    hold_g = 1'b0;
    hwr(8'h60);
    hwr(ln);
    hwr(8'h00);
    hwr(8'h24);
    hwr(ic);
    hwr(8'h0d);
    hwr(8'h26);
    repeat (8) @(negedge i_mclk);
    hold_g = 1'b1;
  endtask : run

  task automatic summarize;
    if (miscompares == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : summarize

  // Main sequence.
  initial
  begin
    repeat (4) @(negedge i_mclk);
    i_rst = 1'b0;
    repeat (2) @(negedge i_mclk);
    // Port A at 0010, 257 bytes, A to B; port B at 0200, pulse only.
    hwr(8'h78);
    hwr(8'h10);
    hwr(8'h00);
    hwr(8'h01);
    hwr(8'h01);
    hwr(8'h3c);
    hwr(8'h00);
    hwr(8'h02);
    hwr(8'h04);
    hwr(8'h0d);
    hwr(8'h26);
    repeat (10) @(negedge i_mclk) check(o_bus_request_line_oe_n, 1'b1);
    ext_req = 1'b1;
    ready = 1'b1;
    repeat (10) @(negedge i_mclk) check(o_bus_request_line_oe_n, 1'b1);
    ext_req = 1'b0;
    wait_req(1'b0);
    repeat (5) @(negedge i_mclk) check({o_addr_oe_n, o_grant_out_n}, 2'b11);
    cnt_on = 1'b1;
    hold_g = 1'b0;
    repeat (20) @(negedge i_mclk);
    check({o_addr_oe_n, o_ctl_oe_n, o_grant_out_n}, 3'b001);
    wait_req(1'b1);
    repeat (3) @(negedge i_mclk);
    cnt_on = 1'b0;
    hold_g = 1'b1;
    check(pulses, 1);
    for (int i = 0; i < 257; i++)
    begin
      src_a = 16'h0010 + 16'(i);
      check(i_mem.mem[16'h0200 + i], {8'h00, src_a[7:0] ^ {src_a[9:8], 6'h2a}});
    end
    hwr(8'h46);
    for (int j = 0; j < 7; j++)
    begin
      hrd(rb[j]);
    end
    check(rb[0][ST_B_END], 1'b1);
    check({rb[2], rb[1]}, 16'h0101);
    check({rb[4], rb[3], rb[6], rb[5]}, 32'h0111_0301);
    // Zero length with end interrupt: the block ends at once.
    run(8'h00, 8'h02);
    check(o_int_oe_n, 1'b0);
    irq_in = 1'b0;
    @(negedge i_mclk);
    check(o_irq_en_out, 1'b0);
    @(negedge i_mclk);
    check(o_int_oe_n, 1'b1);
    irq_in = 1'b1;
    hwr(8'h56);
    check(o_int_oe_n, 1'b1);
    check(o_irq_en_out, 1'b1);
    // Search for the byte copied to port B; only a match may interrupt.
    hwr(8'h1b);
    hwr(8'h00);
    hwr(8'h3a);
    run(8'h01, 8'h01);
    check(o_int_oe_n, 1'b0);
    hwr(8'h16);
    check(o_int_oe_n, 1'b1);
    run(8'h00, 8'h02);
    check(o_int_oe_n, 1'b0);
    @(negedge i_mclk);
    fetch_n = 1'b0;
    repeat (4) @(negedge i_mclk);
    fetch_n = 1'b1;
    repeat (3) @(negedge i_mclk);
    check({o_int_oe_n, o_data_oe_n}, 2'b11);
    summarize();
  end
endmodule : dtc_top_tb

`default_nettype wire
